/* core/scd_pkg.sv */
// Summary of operation
// - Instruction clock is the selected system clock divided by three, always running.
// - One instruction clock period forms exactly one machine cycle.
// - Mode bits 3:2 set each phase to 1, 2, 4 or 8 source ticks, dividing the source by 2, 4, 8 or 16.
// - Mode bit 0 set picks ring oscillator; bit 0 clear picks main input, whatever bit 1 holds.
// - After reset the system clock is the ring oscillator divided by sixteen.
// - Main input may be any external source; ring clock only from internal oscillator.
package scd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SCD_MODE_OFFSET = 12'h000;
  localparam logic [11:0] SCD_STATUS_OFFSET = 12'h004;

  // ----------------------------------------------------------------
  // Mode field layout and reset value
  // ----------------------------------------------------------------
  localparam int SCD_MODE_W = 4;
  localparam int SCD_SRC_BIT = 0;
  localparam int SCD_DIV_LSB = 2;
  localparam logic [3:0] SCD_MODE_RESET = 4'hd;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int SCD_INSTR_DIV = 3;
  localparam int SCD_CLK_MHZ = 50;
  localparam int SCD_RING_TICK_CYCLES = 4;

  // Index of the last source tick in a system clock phase (ratio minus one) for a 2-bit ratio code
  function automatic logic [2:0] scd_ratio_last(input logic [1:0] code);
    case (code)
      2'b00: scd_ratio_last = 3'h0;
      2'b01: scd_ratio_last = 3'h1;
      2'b10: scd_ratio_last = 3'h3;
      default: scd_ratio_last = 3'h7;
    endcase
  endfunction

endpackage

/* core/scd_ring_osc.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// On-chip oscillator model: a free tick divider off the system clk
// ----------------------------------------------------------------
module scd_ring_osc import scd_pkg::*; #(
  parameter int TICK_CYCLES = SCD_RING_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic ring_tick
);

  logic [7:0] cnt_reg;

  // Tick once every TICK_CYCLES clocks; internal only, no pin feeds it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
      ring_tick <= 1'b0;
    end else begin
      ring_tick <= (cnt_reg == 8'(TICK_CYCLES - 1));
      cnt_reg <= (cnt_reg == 8'(TICK_CYCLES - 1)) ? 8'h00 : cnt_reg + 8'h01;
    end
  end

endmodule // scd_ring_osc

/* core/scd_instr_div.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Divide system clock ticks by three into instruction clock ticks
// ----------------------------------------------------------------
module scd_instr_div import scd_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sys_tick,
  output logic instr_tick,
  output logic instr_clk
);

  logic [1:0] phase_reg;

  // Runs for every source and ratio, never gated by mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= 2'h0;
      instr_tick <= 1'b0;
      instr_clk <= 1'b0;
    end else begin
      instr_tick <= 1'b0;
      if (sys_tick) begin
        if (phase_reg == 2'(SCD_INSTR_DIV - 1)) begin
          phase_reg <= 2'h0;
          instr_tick <= 1'b1;
        end else begin
          phase_reg <= phase_reg + 2'h1;
        end
        instr_clk <= (phase_reg == 2'(SCD_INSTR_DIV - 1));
      end
    end
  end

endmodule // scd_instr_div

/* core/scd_top.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// System clock select and divide, with APB register access
// ----------------------------------------------------------------
module scd_top import scd_pkg::*; #(
  parameter int RING_TICK_CYCLES = SCD_RING_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic main_osc_input,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic system_clock,
  output logic sys_tick,
  output logic instr_tick,
  output logic instr_clk
);

  // ----------------------------------------------------------------
  // Registers and internal state
  // ----------------------------------------------------------------
  logic [3:0] clock_mode_reg;
  logic [3:0] applied_mode_reg;
  logic [2:0] src_cnt_reg;
  logic ring_tick;
  logic raw_tick;
  logic align_reg;
  logic src_tick;
  logic phase_end;
  logic wr_hit;
  logic rd_go;

  // ----------------------------------------------------------------
  // Source ticks
  // ----------------------------------------------------------------
  scd_ring_osc #(
    .TICK_CYCLES(RING_TICK_CYCLES)
  ) u_ring (
    .clk(clk),
    .arst_n(arst_n),
    .ring_tick(ring_tick)
  );

  // Bit 0 alone picks the ring; bit 1 does not matter
  assign raw_tick = applied_mode_reg[SCD_SRC_BIT] ? ring_tick : main_osc_input;

  // The first tick of a new source may come at any point of its period, so it is dropped
  assign src_tick = raw_tick && !align_reg;

  // Set on a real mode change, cleared by the first raw tick of the new source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      align_reg <= 1'b0;
    end else if (phase_end && system_clock && (clock_mode_reg != applied_mode_reg)) begin
      align_reg <= 1'b1;
    end else if (raw_tick) begin
      align_reg <= 1'b0;
    end
  end

  // Last source tick of one system clock phase
  assign phase_end = src_tick &&
    (src_cnt_reg == scd_ratio_last(applied_mode_reg[SCD_DIV_LSB +: 2]));

  // ----------------------------------------------------------------
  // Divider and system clock
  // ----------------------------------------------------------------
  // Count source ticks; each phase of system_clock lasts ratio ticks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_cnt_reg <= 3'h0;
    end else if (phase_end) begin
      src_cnt_reg <= 3'h0;
    end else if (src_tick) begin
      src_cnt_reg <= src_cnt_reg + 3'h1;
    end
  end

  // Toggle at each phase end; a rising toggle is one system clock tick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      system_clock <= 1'b0;
      sys_tick <= 1'b0;
    end else begin
      sys_tick <= phase_end && !system_clock;
      if (phase_end) begin
        system_clock <= !system_clock;
      end
    end
  end

  // New mode only takes over at the end of a high phase, so no phase is cut short
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      applied_mode_reg <= SCD_MODE_RESET;
    end else if (phase_end && system_clock) begin
      applied_mode_reg <= clock_mode_reg;
    end
  end

  // ----------------------------------------------------------------
  // Instruction clock
  // ----------------------------------------------------------------
  scd_instr_div u_instr (
    .clk(clk),
    .arst_n(arst_n),
    .sys_tick(sys_tick),
    .instr_tick(instr_tick),
    .instr_clk(instr_clk)
  );

  // ----------------------------------------------------------------
  // APB slave: one wait state, pready pulses for one cycle
  // ----------------------------------------------------------------
  assign wr_hit = psel && penable && !pready && pwrite && (paddr == SCD_MODE_OFFSET);
  assign rd_go = psel && penable && !pready;

  // Mode register; the ring always runs, so software can pick it at any time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_mode_reg <= SCD_MODE_RESET;
    end else if (wr_hit) begin
      clock_mode_reg <= pwdata[SCD_MODE_W-1:0];
    end
  end

  // Answer with read data and error in the same registered cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_go;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (rd_go) begin
        case (paddr)
          SCD_MODE_OFFSET: prdata <= pwrite ? 32'h0000_0000 : {28'h0000000, clock_mode_reg};
          SCD_STATUS_OFFSET: begin
            prdata <= pwrite ? 32'h0000_0000 : {28'h0000000, applied_mode_reg};
            pslverr <= pwrite; // Status is read only
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // scd_top

/* testbench/scd_checker.sv */
`timescale 1ns/1ps
// ----
// Bus and clock checks
// ----
module scd_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic system_clock,
  input wire logic sys_tick,
  input wire logic instr_tick
);
  logic [2:0] st_cnt_reg;
  // System ticks since the last machine cycle start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) st_cnt_reg <= 3'h0;
    else st_cnt_reg <= instr_tick ? 3'h0 : st_cnt_reg + {2'h0, sys_tick};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_apb_answer: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_err_qual: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  a_tick_rise: assert property ($rose(system_clock) |-> sys_tick) else $error("tick missing");
  a_tick_cause: assert property (sys_tick |-> system_clock && !$past(system_clock))
    else $error("tick without rise");
  a_tick_pulse: assert property (sys_tick |=> !sys_tick) else $error("tick held");
  a_machine_third: assert property (instr_tick |-> st_cnt_reg + {2'h0, sys_tick} == 3'h3)
    else $error("machine cycle not three ticks");
  c_instr: cover property (instr_tick);
  c_err: cover property (pslverr);
  c_fall: cover property ($fell(system_clock));
endmodule // scd_checker
bind scd_top scd_checker u_scd_checker (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .system_clock(system_clock), .sys_tick(sys_tick),
  .instr_tick(instr_tick));

/* testbench/scd_top_tb_top.sv */
`timescale 1ns/1ps
// ----
// Testbench
// ----
module scd_top_tb_top import scd_pkg::*; ;
  localparam int RT = 4;
  logic clk = 1'b0, arst_n = 1'b0, main_osc_input = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, system_clock, sys_tick, instr_tick, instr_clk, sc_q = 1'b0;
  int error_cnt = 0, samples_checked = 0, cyc = 0, m = 2, mc = 0, ph = 0, min_ph = 999, cur, n;
  logic [32:0] exp_q[$];
  always #10 clk = ~clk;
  scd_top #(.RING_TICK_CYCLES(RT)) u_scd_top (.clk(clk), .arst_n(arst_n), .main_osc_input(main_osc_input),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .system_clock(system_clock), .sys_tick(sys_tick),
    .instr_tick(instr_tick), .instr_clk(instr_clk));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; the expected {pslverr, prdata} goes to the monitor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(negedge clk); while (pready !== 1'b1);
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Answer monitor: pready stands one cycle, so look mid-cycle
  always @(negedge clk) if (pready === 1'b1) chk({pslverr, prdata}, exp_q.pop_front());
  // Main oscillator ticks, one every m clocks
  always @(posedge clk) begin
    mc <= (mc + 1) % m;
    main_osc_input <= (mc == m - 1);
  end
  // Shortest system clock phase seen; a glitchy switch shows up here
  always @(posedge clk) begin
    sc_q <= system_clock;
    ph <= (system_clock !== sc_q) ? 1 : ph + 1;
    if (system_clock !== sc_q && ph < min_ph) min_ph <= ph;
  end
  // Clocks between machine cycle starts
  task automatic inst(input int l);
    n = 0;
    do @(negedge clk); while (instr_tick !== 1'b1);
    do begin
      @(negedge clk);
      n++;
    end while (instr_tick !== 1'b1);
    chk(n, 6 * l);
  endtask
  task automatic run_mode(input logic [3:0] md);
    int l = (1 << md[3:2]) * (md[0] ? RT : m);
    min_ph = 999;
    apb(1'b1, SCD_MODE_OFFSET, {28'($urandom() >> 4), md}, 33'h0);
    repeat (4 * cur + 4 * l + 8) @(posedge clk);
    chk(min_ph, l < cur ? l : cur);
    apb(1'b0, SCD_MODE_OFFSET, 32'h0, {29'h0, md});
    apb(1'b0, SCD_STATUS_OFFSET, 32'h0, {29'h0, md});
    inst(l);
    cur = l;
  endtask
  initial begin
    void'($urandom(43741));
    m = $urandom() % 3 + 2;
    cur = 8 * RT;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, SCD_MODE_OFFSET, 32'h0, {29'h0, SCD_MODE_RESET});
    inst(8 * RT);
    apb(1'b1, SCD_STATUS_OFFSET, $urandom(), {1'b1, 32'h0});
    apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 16; i++) run_mode(4'(i));
    test_done();
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end
endmodule // scd_top_tb_top
